// file: core/plt_pkg.sv
// Behaviour
// - carrier sense within 17.5 bit times
// - each burst pulse lasts 100 ns
// - clock pulses 125 us apart, 111..139
// - one-bit data pulse 62.5 us after clock
// - burst holds 17 to 33 pulses
// - burst spans 2 ms first to last
// - bursts start 8 to 24 ms apart
// - same limits for sent and received bursts; receive checks the 111..139 clock gap, the 17 to 33 pulse count and 16 bits per burst
// - signal detect asserts within 1 ms
// - signal detect drops within 300 us
// - latch straps 3 us after reset release
// - straps become outputs 50 ns later
// - loopback receive dead time up to 550 us
// - loopback keeps transmit outputs inactive
// - loopback transmit enable bit drives outputs
// - isolate clear reaches normal in 100 us
// - reset release reaches normal in 500 us
package plt_pkg;
  localparam int unsigned CLK_NS        = 50;      // reference clock period
  localparam int unsigned PULSE_NS      = 100;     // pulse width
  localparam int unsigned CLK_GAP_NS    = 125000;  // clock to clock pulse
  localparam int unsigned DATA_GAP_NS   = 62500;   // clock to data pulse
  localparam int unsigned CLK_MIN_NS    = 111000;  // shortest accepted gap
  localparam int unsigned CLK_MAX_NS    = 139000;  // longest accepted gap
  localparam int unsigned BURST_GAP_NS  = 16000000; // burst start spacing
  localparam int unsigned SD_ON_NS      = 500000;  // sd qualify, under 1 ms
  localparam int unsigned SD_OFF_NS     = 200000;  // sd drop, under 300 us
  localparam int unsigned STRAP_NS      = 3000;    // strap latch delay
  localparam int unsigned DRV_NS        = 50;      // strap to driver delay
  localparam int unsigned ISO_NS        = 50000;   // isolate exit, under 100 us
  localparam int unsigned RST_ISO_NS    = 400000;  // reset to normal, under 500 us
  localparam int unsigned DEAD_NS       = 550000;  // loopback dead time
  localparam int unsigned PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CLK_GAP_CYC   = CLK_GAP_NS / CLK_NS;
  localparam int unsigned DATA_GAP_CYC  = DATA_GAP_NS / CLK_NS;
  localparam int unsigned CLK_MIN_CYC   = CLK_MIN_NS / CLK_NS;
  localparam int unsigned CLK_MAX_CYC   = CLK_MAX_NS / CLK_NS;
  localparam int unsigned BURST_GAP_CYC = BURST_GAP_NS / CLK_NS;
  localparam int unsigned SD_ON_CYC     = SD_ON_NS / CLK_NS;
  localparam int unsigned SD_OFF_CYC    = SD_OFF_NS / CLK_NS;
  localparam int unsigned STRAP_CYC     = (STRAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DRV_CYC       = (DRV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ISO_CYC       = ISO_NS / CLK_NS;
  localparam int unsigned RST_ISO_CYC   = RST_ISO_NS / CLK_NS;
  localparam int unsigned DEAD_CYC      = DEAD_NS / CLK_NS;
  localparam int unsigned BITS          = 16;      // data bits per burst
  localparam int unsigned MIN_PULSES    = 17;
  localparam int unsigned MAX_PULSES    = 33;
  localparam int unsigned STRAPS        = 8;       // strap pin count
  localparam int unsigned LBK_XMT_BIT   = 0;       // loopback control bit
  localparam int unsigned ISO_BIT       = 10;      // isolate control bit
  localparam int unsigned CRS_CYC       = 1;       // carrier sense latency
  localparam logic [STRAPS-1:0] STRAP_RST = 8'h00;
  typedef enum logic [1:0] {
    PLT_TX_IDLE = 2'b00,
    PLT_TX_CLK  = 2'b01,
    PLT_TX_DATA = 2'b11
  } plt_tx_e;
endpackage : plt_pkg

// file: core/plt_core.sv
`timescale 1ns/100ps
module plt_core #(
  parameter int unsigned BURST_GAP_CYC = plt_pkg::BURST_GAP_CYC,
  parameter int unsigned SD_ON_CYC     = plt_pkg::SD_ON_CYC,
  parameter int unsigned DEAD_CYC      = plt_pkg::DEAD_CYC,
  parameter int unsigned RST_ISO_CYC   = plt_pkg::RST_ISO_CYC,
  parameter int unsigned SD_OFF_CYC    = plt_pkg::SD_OFF_CYC,
  parameter int unsigned ISO_CYC       = plt_pkg::ISO_CYC
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       soft_reset_i,
  input  wire logic                       flp_enable_i,
  input  wire logic [plt_pkg::BITS-1:0]   tx_word_i,
  input  wire logic                       rx_pulse_i,
  input  wire logic                       receive_pair_input_i,
  input  wire logic                       ssd_detect_i,
  input  wire logic                       loopback_i,
  input  wire logic [15:0]                loopback_control_register_i,
  input  wire logic [15:0]                basic_mode_control_register_i,
  input  wire logic [plt_pkg::STRAPS-1:0] strap_i,
  output logic                            tp_pulse_o,
  output logic                            twisted_pair_transmit_outputs_o,
  output logic [plt_pkg::BITS-1:0]        rx_word_o,
  output logic                            rx_word_valid_o,
  output logic                            rx_burst_err_o,
  output logic                            signal_detect_internal_o,
  output logic                            carrier_sense_o,
  output logic                            rx_data_gate_o,
  output logic [plt_pkg::STRAPS-1:0]      strap_latched_o,
  output logic                            strap_oe_b_o,
  output logic                            isolate_o
);
  import plt_pkg::*;

  // whole module state
  typedef struct packed {
    plt_tx_e           tx_st;      // burst transmit state
    logic [23:0]       tx_cnt;     // slot timer
    logic [23:0]       gap_cnt;    // burst spacing timer
    logic [4:0]        tx_bit;     // bit slot index
    logic [BITS-1:0]   tx_sh;      // bits being sent
    logic [1:0]        pw_cnt;     // pulse width timer
    logic              pulse;      // pulse on line
    logic              rx_prev;    // last received pulse level
    logic [12:0]       rx_cnt;     // time since last clock pulse
    logic              rx_data;    // data pulse seen in slot
    logic              rx_act;     // burst in progress
    logic [5:0]        rx_np;      // pulses counted
    logic [4:0]        rx_nb;      // bits counted
    logic [BITS-1:0]   rx_sh;      // bits received
    logic [BITS-1:0]   rx_word;    // completed word
    logic              rx_val;     // word strobe
    logic              rx_err;     // burst error strobe
    logic [23:0]       sd_cnt;     // signal detect filter
    logic              sd;         // signal detect
    logic              crs;        // carrier sense
    logic              soft_prev;  // last soft reset level
    logic [23:0]       rst_cnt;    // time since reset release
    logic              strap_done; // straps latched
    logic [STRAPS-1:0] straps;     // latched strap values
    logic              strap_oe_b; // strap driver enable, low drives
    logic              iso;        // isolate mode
    logic [23:0]       iso_cnt;    // isolate exit timer
    logic [23:0]       dead_cnt;   // loopback dead timer
    logic              lbk_prev;   // last loopback level
    logic              gate;       // receive data allowed
    logic              tp_en;      // transmit outputs enabled
  } plt_state_s;

  plt_state_s st;       // registered state
  plt_state_s next_st;  // next state

  // saturating 24-bit increment
  function automatic logic [23:0] sat_inc(input logic [23:0] v);
    sat_inc = (v == 24'hffffff) ? v : v + 24'h000001;
  endfunction : sat_inc

  // all next-state logic
  always_comb begin
    next_st = st;
    next_st.rx_val = 1'b0;
    next_st.rx_err = 1'b0;
    next_st.soft_prev = soft_reset_i;
    next_st.lbk_prev = loopback_i;

    // pulse width stretch
    if (st.pw_cnt != 2'h0) begin
      next_st.pw_cnt = st.pw_cnt - 2'h1;
    end else begin
      next_st.pulse = 1'b0;
    end

    // burst spacing timer, fixed 16 ms start to start
    next_st.gap_cnt = sat_inc(st.gap_cnt);
    unique case (st.tx_st)
      PLT_TX_IDLE: begin
        if (flp_enable_i && st.gap_cnt >= 24'(BURST_GAP_CYC - 1)) begin
          next_st.gap_cnt = 24'h0;
          next_st.tx_st = PLT_TX_CLK;
          next_st.tx_sh = tx_word_i;
          next_st.tx_bit = 5'h0;
          next_st.tx_cnt = 24'h0;
          next_st.pulse = 1'b1;  // first clock pulse
          next_st.pw_cnt = 2'(PULSE_CYC - 1);
        end
      end
      PLT_TX_CLK: begin
        next_st.tx_cnt = st.tx_cnt + 24'h1;
        // one bit sends data pulse mid slot, zero omits it
        if (st.tx_cnt == 24'(DATA_GAP_CYC - 1)) begin
          next_st.tx_st = PLT_TX_DATA;
          if (st.tx_sh[0]) begin
            next_st.pulse = 1'b1;
            next_st.pw_cnt = 2'(PULSE_CYC - 1);
          end
        end
      end
      PLT_TX_DATA: begin
        next_st.tx_cnt = st.tx_cnt + 24'h1;
        // next clock pulse 125 us after last
        if (st.tx_cnt == 24'(CLK_GAP_CYC - 1)) begin
          next_st.tx_cnt = 24'h0;
          next_st.tx_sh = st.tx_sh >> 1;
          next_st.tx_bit = st.tx_bit + 5'h1;
          // 17 clock pulses plus up to 16 data, 2 ms span
          next_st.pulse = 1'b1;
          next_st.pw_cnt = 2'(PULSE_CYC - 1);
          next_st.tx_st = (st.tx_bit == 5'(BITS - 1)) ? PLT_TX_IDLE : PLT_TX_CLK;
        end
      end
      default: next_st.tx_st = PLT_TX_IDLE;
    endcase

    // receive checker on rising pulse edges
    next_st.rx_prev = rx_pulse_i;
    if (st.rx_act && st.rx_cnt != 13'h1fff) begin
      next_st.rx_cnt = st.rx_cnt + 13'h1;
    end
    if (rx_pulse_i && !st.rx_prev) begin
      if (!st.rx_act) begin
        next_st.rx_act = 1'b1;
        next_st.rx_cnt = 13'h0;
        next_st.rx_np = 6'h1;
        next_st.rx_nb = 5'h0;
        next_st.rx_data = 1'b0;
      end else if (st.rx_cnt < 13'(CLK_MIN_CYC) && !st.rx_data) begin
        // pulse inside slot is a one
        next_st.rx_data = 1'b1;
        next_st.rx_np = st.rx_np + 6'h1;
      end else if (st.rx_cnt >= 13'(CLK_MIN_CYC) && st.rx_cnt <= 13'(CLK_MAX_CYC)) begin
        // new clock pulse closes slot
        next_st.rx_sh = {st.rx_data, st.rx_sh[BITS-1:1]};
        next_st.rx_nb = st.rx_nb + 5'h1;
        next_st.rx_np = st.rx_np + 6'h1;
        next_st.rx_cnt = 13'h0;
        next_st.rx_data = 1'b0;
      end else begin
        next_st.rx_err = 1'b1;
        next_st.rx_act = 1'b0;
      end
    end else if (st.rx_act && st.rx_cnt > 13'(CLK_MAX_CYC)) begin
      // burst ended, check pulse count
      next_st.rx_act = 1'b0;
      if (st.rx_np >= 6'(MIN_PULSES) && st.rx_np <= 6'(MAX_PULSES)
          && st.rx_nb == 5'(BITS)) begin
        next_st.rx_word = st.rx_sh;
        next_st.rx_val = 1'b1;
      end else begin
        next_st.rx_err = 1'b1;
      end
    end

    // signal detect qualify and drop
    if (receive_pair_input_i != st.sd) begin
      next_st.sd_cnt = sat_inc(st.sd_cnt);
      if (receive_pair_input_i && st.sd_cnt >= 24'(SD_ON_CYC - 1)) begin
        next_st.sd = 1'b1;
        next_st.sd_cnt = 24'h0;
      end
      if (!receive_pair_input_i && st.sd_cnt >= 24'(SD_OFF_CYC - 1)) begin
        next_st.sd = 1'b0;
        next_st.sd_cnt = 24'h0;
      end
    end else begin
      next_st.sd_cnt = 24'h0;
    end
    // carrier sense one cycle after start delimiter
    next_st.crs = st.sd & ssd_detect_i;

    // soft reset restarts strap and isolate sequence
    if (soft_reset_i) begin
      next_st.rst_cnt = 24'h0;
      next_st.strap_done = 1'b0;
      next_st.strap_oe_b = 1'b1;
      next_st.iso = 1'b1;
    end else begin
      next_st.rst_cnt = sat_inc(st.rst_cnt);
      // latch straps 3 us after release
      if (st.rst_cnt == 24'(STRAP_CYC - 1)) begin
        next_st.straps = strap_i;
        next_st.strap_done = 1'b1;
      end
      // turn strap pins into drivers 50 ns later
      if (st.rst_cnt == 24'(STRAP_CYC + DRV_CYC - 1)) begin
        next_st.strap_oe_b = 1'b0;
      end
      // leave isolate after reset
      if (st.rst_cnt == 24'(RST_ISO_CYC - 1)) begin
        next_st.iso = basic_mode_control_register_i[ISO_BIT];
      end
    end

    // isolate bit cleared, normal within 100 us
    if (basic_mode_control_register_i[ISO_BIT]) begin
      next_st.iso_cnt = 24'h0;
      if (st.rst_cnt >= 24'(RST_ISO_CYC)) begin
        next_st.iso = 1'b1;
      end
    end else if (st.iso && st.rst_cnt >= 24'(RST_ISO_CYC)) begin
      next_st.iso_cnt = sat_inc(st.iso_cnt);
      if (st.iso_cnt >= 24'(ISO_CYC - 1)) begin
        next_st.iso = 1'b0;
      end
    end

    // loopback dead time on entry
    if (loopback_i && !st.lbk_prev) begin
      next_st.dead_cnt = 24'h0;
      next_st.gate = 1'b0;
    end else if (loopback_i && !st.gate) begin
      next_st.dead_cnt = sat_inc(st.dead_cnt);
      next_st.gate = (st.dead_cnt >= 24'(DEAD_CYC - 1));
    end else if (!loopback_i) begin
      next_st.gate = 1'b1;
    end

    // transmit outputs quiet in loopback unless enabled
    next_st.tp_en = !loopback_i || loopback_control_register_i[LBK_XMT_BIT];
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.tx_st <= PLT_TX_IDLE;
      st.straps <= STRAP_RST;
      st.strap_oe_b <= 1'b1;
      st.iso <= 1'b1;
      st.gate <= 1'b1;
      st.tp_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tp_pulse_o <= 1'b0;
      twisted_pair_transmit_outputs_o <= 1'b0;
      rx_word_o <= '0;
      rx_word_valid_o <= 1'b0;
      rx_burst_err_o <= 1'b0;
      signal_detect_internal_o <= 1'b0;
      carrier_sense_o <= 1'b0;
      rx_data_gate_o <= 1'b1;
      strap_latched_o <= STRAP_RST;
      strap_oe_b_o <= 1'b1;
      isolate_o <= 1'b1;
    end else begin
      tp_pulse_o <= next_st.pulse;
      twisted_pair_transmit_outputs_o <= next_st.pulse & next_st.tp_en;
      rx_word_o <= next_st.rx_word;
      rx_word_valid_o <= next_st.rx_val;
      rx_burst_err_o <= next_st.rx_err;
      signal_detect_internal_o <= next_st.sd;
      carrier_sense_o <= next_st.crs;
      rx_data_gate_o <= next_st.gate;
      strap_latched_o <= next_st.straps;
      strap_oe_b_o <= next_st.strap_oe_b;
      isolate_o <= next_st.iso;
    end
  end
endmodule : plt_core

// file: testbench/plt_core_monitor.sv
`timescale 1ns/100ps
module plt_core_monitor #(
  parameter int unsigned SD_ON_CYC  = 64,
  parameter int unsigned SD_OFF_CYC = 64
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        soft_reset_i,
  input wire logic        receive_pair_input_i,
  input wire logic        ssd_detect_i,
  input wire logic        loopback_i,
  input wire logic [15:0] loopback_control_register_i,
  input wire logic [15:0] basic_mode_control_register_i,
  input wire logic        tp_pulse_o,
  input wire logic        twisted_pair_transmit_outputs_o,
  input wire logic        signal_detect_internal_o,
  input wire logic        carrier_sense_o,
  input wire logic        rx_data_gate_o,
  input wire logic        strap_oe_b_o,
  input wire logic        isolate_o,
  input wire logic        rx_word_valid_o,
  input wire logic        rx_burst_err_o
);
  import plt_pkg::*;
  logic [15:0] gap_cnt;  // cycles since last burst pulse
  logic [15:0] hi_cnt;   // cycles of steady energy
  logic [15:0] lo_cnt;   // cycles of steady silence
  logic [15:0] rel_cnt;  // cycles since reset release
  logic [15:0] dead_cnt; // cycles of receive gating
  logic [15:0] iso_wait; // cycles isolated after a clear request
  // saturating helper counters
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_cnt <= 16'hffff;
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'h0000;
      rel_cnt <= 16'h0000;
      dead_cnt <= 16'h0000;
      iso_wait <= 16'h0000;
    end else begin
      // runs only while isolate is cleared but still shown, well after reset
      iso_wait <= (basic_mode_control_register_i[ISO_BIT] || !isolate_o
                   || rel_cnt <= 16'h2800) ? 16'h0000 : iso_wait + {15'h0000, ~&iso_wait};
      gap_cnt <= $rose(tp_pulse_o) ? 16'h0000 : gap_cnt + {15'h0000, ~&gap_cnt};
      hi_cnt <= receive_pair_input_i ? hi_cnt + {15'h0000, ~&hi_cnt} : 16'h0000;
      lo_cnt <= receive_pair_input_i ? 16'h0000 : lo_cnt + {15'h0000, ~&lo_cnt};
      rel_cnt <= soft_reset_i ? 16'h0000 : rel_cnt + {15'h0000, ~&rel_cnt};
      dead_cnt <= rx_data_gate_o ? 16'h0000 : dead_cnt + {15'h0000, ~&dead_cnt};
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_pulse_width: assert property ($rose(tp_pulse_o) |=> tp_pulse_o ##1 !tp_pulse_o)
    else $error("burst pulse width wrong");
  chk_pulse_gap: assert property ($rose(tp_pulse_o) |->
    (gap_cnt == 16'h04e1 || gap_cnt == 16'h09c3 || gap_cnt > 16'h1388))
    else $error("burst pulse spacing wrong");
  chk_strap_drive: assert property ($fell(strap_oe_b_o) |->
    (rel_cnt >= 16'h003b && rel_cnt <= 16'h003f)) else $error("strap drive time wrong");
  chk_iso_exit: assert property (iso_wait < 16'h07d0)
    else $error("isolate exit late");
  chk_iso_normal: assert property (rel_cnt == 16'h2710
    && !basic_mode_control_register_i[ISO_BIT] |-> !isolate_o) else $error("still isolated");
  chk_sd_on: assert property (hi_cnt > SD_ON_CYC + 2 |-> signal_detect_internal_o)
    else $error("signal detect late");
  chk_sd_off: assert property (lo_cnt > SD_OFF_CYC + 2 |-> !signal_detect_internal_o)
    else $error("signal detect stuck");
  chk_crs_on: assert property ((signal_detect_internal_o && ssd_detect_i)[*3]
    |-> carrier_sense_o) else $error("carrier sense late");
  chk_lbk_mute: assert property ((loopback_i && !loopback_control_register_i[LBK_XMT_BIT])[*3]
    |-> !twisted_pair_transmit_outputs_o) else $error("transmit active in loopback");
  chk_lbk_pass: assert property ((!loopback_i || loopback_control_register_i[LBK_XMT_BIT])[*3]
    ##0 $rose(tp_pulse_o) |-> ##[0:1] twisted_pair_transmit_outputs_o) else $error("pulse lost");
  chk_dead_gate: assert property ($rose(loopback_i) |-> ##[1:3] !rx_data_gate_o)
    else $error("no dead time");
  chk_dead_end: assert property (dead_cnt < 16'h2af9)
    else $error("dead time too long");
  // main scenarios reached
  cover property ($rose(tp_pulse_o));
  cover property (rx_word_valid_o);
  cover property (rx_burst_err_o);
  cover property ($fell(strap_oe_b_o));
endmodule : plt_core_monitor
bind plt_core plt_core_monitor #(.SD_ON_CYC(SD_ON_CYC), .SD_OFF_CYC(SD_OFF_CYC)) u_mon (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .soft_reset_i(soft_reset_i),
  .receive_pair_input_i(receive_pair_input_i), .ssd_detect_i(ssd_detect_i),
  .loopback_i(loopback_i), .loopback_control_register_i(loopback_control_register_i),
  .basic_mode_control_register_i(basic_mode_control_register_i), .tp_pulse_o(tp_pulse_o),
  .twisted_pair_transmit_outputs_o(twisted_pair_transmit_outputs_o),
  .signal_detect_internal_o(signal_detect_internal_o), .carrier_sense_o(carrier_sense_o),
  .rx_data_gate_o(rx_data_gate_o), .strap_oe_b_o(strap_oe_b_o), .isolate_o(isolate_o),
  .rx_word_valid_o(rx_word_valid_o), .rx_burst_err_o(rx_burst_err_o));

// file: testbench/plt_link_partner.sv
`timescale 1ns/100ps
module plt_link_partner (
  input  wire logic sys_clk_i,
  output logic      rx_pulse_o
);
  // line rests low between pulses
  initial begin
    rx_pulse_o = 1'b0;
  end
  // one link pulse, two cycles wide
  task automatic pulse();
    @(negedge sys_clk_i);
    rx_pulse_o = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rx_pulse_o = 1'b0;
  endtask : pulse
  // full burst, bit 0 first
  task automatic send_burst(input logic [15:0] w);
    for (int i = 0; i < 17; i++) begin
      pulse();
      if (i < 16 && w[i]) begin
        repeat (1247) @(negedge sys_clk_i);
        pulse();
        repeat (1247) @(negedge sys_clk_i);
      end else if (i < 16) begin
        repeat (2497) @(negedge sys_clk_i);
      end
    end
  endtask : send_burst
  // two pulses far off any slot
  task automatic stray();
    pulse();
    repeat (500) @(negedge sys_clk_i);
    pulse();
  endtask : stray
endmodule : plt_link_partner

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import plt_pkg::*;
  localparam int unsigned GAP = 46000; // shortened spacing, longer than one burst plus 5000
  localparam int unsigned SH  = 64;    // shortened qualify times
  logic sys_clk_i = 1'b0;
  logic rst_b_i, soft_reset_i, flp_enable_i, receive_pair_input_i, ssd_detect_i, loopback_i;
  logic [15:0] tx_word_i, loopback_control_register_i, basic_mode_control_register_i, rw;
  logic [STRAPS-1:0] strap_i, strap_latched_o;
  logic [15:0] rx_word_o, tw, q_tx[$], q_rx[$];
  logic rx_pulse_i, tp_pulse_o, tpo, rx_word_valid_o, rx_burst_err_o, sd, crs, gate, oe_b, iso;
  logic tp_q;
  int seed, error_cnt, n_checks, n_err, tgap, nclk, npul, mute, pass;
  plt_core #(.BURST_GAP_CYC(GAP), .SD_ON_CYC(SH), .DEAD_CYC(SH), .RST_ISO_CYC(SH),
    .SD_OFF_CYC(SH), .ISO_CYC(SH)) dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .soft_reset_i(soft_reset_i),
    .flp_enable_i(flp_enable_i), .tx_word_i(tx_word_i), .rx_pulse_i(rx_pulse_i),
    .receive_pair_input_i(receive_pair_input_i), .ssd_detect_i(ssd_detect_i),
    .loopback_i(loopback_i), .loopback_control_register_i(loopback_control_register_i),
    .basic_mode_control_register_i(basic_mode_control_register_i), .strap_i(strap_i),
    .tp_pulse_o(tp_pulse_o), .twisted_pair_transmit_outputs_o(tpo), .rx_word_o(rx_word_o),
    .rx_word_valid_o(rx_word_valid_o), .rx_burst_err_o(rx_burst_err_o),
    .signal_detect_internal_o(sd), .carrier_sense_o(crs), .rx_data_gate_o(gate),
    .strap_latched_o(strap_latched_o), .strap_oe_b_o(oe_b), .isolate_o(iso));
  plt_link_partner partner (.sys_clk_i(sys_clk_i), .rx_pulse_o(rx_pulse_i));
  // 20 MHz clock
  always #25 sys_clk_i = ~sys_clk_i;
  // compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // verdict and stop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // decode transmitted bursts
  always @(posedge sys_clk_i) begin
    tgap++;
    if (tp_pulse_o === 1'b1 && tp_q !== 1'b1) begin
      if (nclk != 0 && tgap < 1800) tw[nclk-1] = 1'b1;
      else begin
        if (nclk != 0) check("clock gap", 16'(tgap > 2220 && tgap < 2780), 16'h0001);
        nclk++;
        tgap = 0;
      end
      npul++;
    end else if (nclk != 0 && tgap == 5000) begin
      check("tx word", tw, q_tx.pop_front());
      check("clock pulses", 16'(nclk), 16'h0011);
      check("pulses", 16'(npul), 16'(17 + $countones(tx_word_i)));
      nclk = 0;
      npul = 0;
      tw = 16'h0000;
    end
    tp_q = tp_pulse_o;
  end
  // received words and errors
  always @(posedge sys_clk_i) begin
    if (rx_word_valid_o === 1'b1) check("rx word", rx_word_o, q_rx.pop_front());
    if (rx_burst_err_o === 1'b1) n_err++;
  end
  // loopback muting during the sent burst
  initial begin
    wait (tp_pulse_o === 1'b1);
    @(negedge sys_clk_i);
    loopback_i = 1'b1;
    repeat (10000) @(negedge sys_clk_i) mute += (tpo === 1'b1);
    loopback_control_register_i = 16'h0001;
    repeat (10000) @(negedge sys_clk_i) pass += (tpo === 1'b1);
    loopback_i = 1'b0;
    check("muted pulses", 16'(mute), 16'h0000);
    check("passed pulses", 16'(pass != 0), 16'h0001);
    $display("test loopback transmit done");
  end
  // watchdog
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    {rst_b_i, soft_reset_i, receive_pair_input_i, ssd_detect_i, loopback_i} = 5'h00;
    {loopback_control_register_i, basic_mode_control_register_i, tgap, nclk, npul} = '0;
    seed = 18317;
    flp_enable_i = 1'b1;
    strap_i = $random(seed);
    tx_word_i = $random(seed);
    rw = $random(seed);
    tw = 16'h0000;
    q_tx.push_back(tx_word_i);
    repeat (4) @(negedge sys_clk_i);
    check("reset outputs", {iso, oe_b, gate, tp_pulse_o}, 16'h000e);
    repeat (4) @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (70) @(negedge sys_clk_i);
    check("straps", strap_latched_o, strap_i);
    check("strap drive", {oe_b, iso}, 16'h0000);
    $display("test reset done");
    {receive_pair_input_i, ssd_detect_i} = 2'b11;
    repeat (SH + 6) @(negedge sys_clk_i);
    check("detect on", {sd, crs}, 16'h0003);
    receive_pair_input_i = 1'b0;
    repeat (SH + 6) @(negedge sys_clk_i);
    check("detect off", {sd, crs}, 16'h0000);
    loopback_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check("dead gate", gate, 16'h0000);
    repeat (SH + 4) @(negedge sys_clk_i);
    check("gate open", gate, 16'h0001);
    loopback_i = 1'b0;
    $display("test detect and dead time done");
    q_rx.push_back(rw);
    partner.send_burst(rw);
    repeat (3000) @(negedge sys_clk_i);
    check("no rx error", 16'(n_err), 16'h0000);
    partner.stray();
    repeat (3000) @(negedge sys_clk_i);
    check("rx error", 16'(n_err != 0), 16'h0001);
    for (int n = 0; n < 60000 && q_tx.size() != 0; n++) @(negedge sys_clk_i);
    flp_enable_i = 1'b0;
    check("bursts left", 16'(q_tx.size() + q_rx.size()), 16'h0000);
    $display("test bursts done");
    basic_mode_control_register_i = 16'h0400;
    repeat (SH + 6) @(negedge sys_clk_i);
    check("isolate on", iso, 16'h0001);
    basic_mode_control_register_i = 16'h0000;
    repeat (SH + 6) @(negedge sys_clk_i);
    check("isolate off", iso, 16'h0000);
    strap_i = $random(seed);
    soft_reset_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    soft_reset_i = 1'b0;
    repeat (70) @(negedge sys_clk_i);
    check("soft straps", strap_latched_o, strap_i);
    $display("test isolate and soft reset done");
    end_of_test();
  end
endmodule : testbench
